// file: include/pdsrc_pkg.sv
// Shared constants and carrier types of the source power path output block
package pdsrc_pkg;
   // ***********************************************
   // Timing
   // ***********************************************
   localparam int unsigned CLK_KHZ          = 250000;
   localparam int unsigned TRANS_WINDOW_MS  = 280;
   localparam int unsigned TRANS_WINDOW_CYC = TRANS_WINDOW_MS * CLK_KHZ;
   localparam int unsigned ERR_RECOVERY_MS  = 25;
   localparam int unsigned ERR_RECOVERY_CYC = ERR_RECOVERY_MS * CLK_KHZ;
   // ***********************************************
   // Profiles and reset values
   // ***********************************************
   localparam int unsigned MAX_PROFILES   = 5;
   localparam int unsigned FLAG_COUNT     = 4;
   localparam int unsigned FIRST_FLAGGED  = 2;
   localparam logic [3:0]  FLAGS_OFF      = 4'h0;
   localparam logic        ADDR_BIT0_RST  = 1'h0;

   // Asynchronous levels from analog comparators and the strap pin
   typedef struct packed {
      logic vbus_valid;                   // Bus inside valid range
      logic vbus_present;                 // Bus voltage present
      logic vdd_uv_ok;                    // Supply above undervoltage
      logic vdd_ov_ok;                    // Supply below overvoltage
      logic addr_strap;                   // Address select pin level
   } pdsrc_sense_type;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_TRANS,
      ST_ACTIVE,
      ST_ERROR
   } pdsrc_state_type;
endpackage

// file: design/pdsrc_outputs.sv
// Power path, profile flag, discharge and strap logic of a PD source
// Function
// - Keep both CC pins high-impedance while reset is held.
// - Enable path only when attached and bus valid, or attached in a profile step window; open-drain, low.
// - Mirror power path pin level on a readable status bit.
// - Optional supply UVLO and OVLO independently withhold the path enable.
// - Sample address strap once after start-up, hold as address bit 0.
// - Four open-drain active-low flags mark profiles two to five selected.
// - Up to five advertised profiles may be negotiated.
// - Drive an external discharge command beside the internal discharge.
// - Bus sense gives presence and valid-range monitoring.
// - Bus leaving valid range drops connection, path, enters error recovery.
// - Suspend monitoring for a transition window; discharge on downward step.
// - Discharge on detach and during error recovery.
`timescale 1ns/1ns
`default_nettype none
module pdsrc_outputs #(
   parameter int unsigned TRANS_CYCLES = pdsrc_pkg::TRANS_WINDOW_CYC,
   parameter int unsigned ERR_CYCLES   = pdsrc_pkg::ERR_RECOVERY_CYC,
   parameter int unsigned PROFILES     = pdsrc_pkg::MAX_PROFILES
) (
   input  wire logic                      clk_i,         // 250 MHz clock
   input  wire logic                      rst_i,         // Async reset
   input  wire logic                      ce_i,          // Clock enable
   input  wire pdsrc_pkg::pdsrc_sense_type sense_i,      // Async levels
   input  wire logic                      attached_i,    // Sink attached
   input  wire logic                      contract_i,    // Contract held
   input  wire logic [2:0]                profile_i,     // Profile 1..5
   input  wire logic [2:0]                profile_cnt_i, // Advertised
   input  wire logic                      uvlo_sel_i,    // Use UVLO
   input  wire logic                      ovlo_sel_i,    // Use OVLO
   input  wire logic                      disch_en_i,    // Discharge on
   output logic                           cc_hiz_o,      // CC released
   output logic                           source_power_path_enable_n_o,
   output logic                           path_oe_o,     // Path pin drive
   output logic                           path_status_o, // Pin level bit
   output logic [3:0]                     profile_select_flag_n_o,
   output logic [3:0]                     flag_oe_o,     // Flag drive
   output logic                           external_discharge_ctrl_o,
   output logic                           internal_discharge_o,
   output logic                           i2c_addr_bit0_o, // Strap
   output logic                           connected_o,   // Link held
   output logic                           error_recovery_o // In recovery
);
   import pdsrc_pkg::*;

   localparam int TW = $clog2(TRANS_CYCLES + 1);
   localparam int EW = $clog2(ERR_CYCLES + 1);

   // ***********************************************
   // Elaboration checks
   // ***********************************************
   if (TRANS_CYCLES < 1 || ERR_CYCLES < 1 || PROFILES > MAX_PROFILES ||
       PROFILES < 1) begin : g_bad
      $error("pdsrc_outputs: unsupported parameter value");
   end

   // Flag one-hot for a profile, only if advertised in the table
   function automatic logic [3:0] flag_decode(input logic [2:0] p,
                                              input logic [2:0] cnt);
      logic [3:0] f;
      f = FLAGS_OFF;
      if (p >= 3'(FIRST_FLAGGED) && p <= cnt && p <= 3'(PROFILES)) begin
         f = 4'h1 << (p - 3'(FIRST_FLAGGED));
      end
      return f;
   endfunction

   // ***********************************************
   // Synchronisers
   // ***********************************************
   pdsrc_sense_type meta_reg, sync_reg;

   // Two stages; only sync_reg feeds logic
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else if (ce_i) begin
         meta_reg <= sense_i;
         sync_reg <= meta_reg;
      end
   end

   // ***********************************************
   // CC release and address strap
   // ***********************************************
   logic cc_hiz_reg, strap_wait_reg, strap_done_reg, addr_bit0_reg;

   // CC stays released until the first enabled edge after reset
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cc_hiz_reg <= 1'b1;
      end else if (ce_i) begin
         cc_hiz_reg <= 1'b0;
      end
   end

   // Synchroniser clears in reset, so the strap waits until it has refilled
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         strap_wait_reg <= 1'b0;
         strap_done_reg <= 1'b0;
         addr_bit0_reg  <= ADDR_BIT0_RST;
      end else if (ce_i) begin
         strap_wait_reg <= !cc_hiz_reg;
         if (strap_wait_reg && !strap_done_reg) begin
            strap_done_reg <= 1'b1;
            addr_bit0_reg  <= sync_reg.addr_strap;
         end
      end
   end

   // ***********************************************
   // Connection state machine
   // ***********************************************
   pdsrc_state_type state_reg, state_next;
   logic [TW-1:0]   win_reg;
   logic [EW-1:0]   err_reg;
   logic [2:0]      prof_reg;
   logic            step_reg, down_reg, attach_win_reg;
   logic            prof_change;

   assign prof_change = contract_i && profile_i != prof_reg;

   // Next state; monitoring ignored inside the window
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (attached_i) begin
               state_next = ST_TRANS;
            end
         end
         ST_TRANS: begin
            if (!attached_i) begin
               state_next = ST_IDLE;
            end else if (win_reg == TW'(TRANS_CYCLES - 1)) begin
               state_next = sync_reg.vbus_valid ? ST_ACTIVE
                                                : ST_ERROR;
            end
         end
         ST_ACTIVE: begin
            if (!attached_i) begin
               state_next = ST_IDLE;
            end else if (!sync_reg.vbus_valid) begin
               state_next = ST_ERROR;
            end else if (prof_change) begin
               state_next = ST_TRANS;
            end
         end
         ST_ERROR: begin
            if (err_reg == EW'(ERR_CYCLES - 1)) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
      end else if (ce_i) begin
         state_reg <= state_next;
      end
   end

   // Window and recovery timers restart on every state entry
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         win_reg <= '0;
         err_reg <= '0;
      end else if (ce_i) begin
         win_reg <= (state_next == ST_TRANS && state_reg == ST_TRANS)
                    ? win_reg + 1'b1 : '0;
         err_reg <= (state_next == ST_ERROR && state_reg == ST_ERROR)
                    ? err_reg + 1'b1 : '0;
      end
   end

   // Profile tracking; a lower number is a downward voltage step
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prof_reg       <= 3'h1;
         down_reg       <= 1'b0;
         attach_win_reg <= 1'b0;
      end else if (ce_i) begin
         if (state_reg == ST_IDLE && state_next == ST_TRANS) begin
            prof_reg       <= 3'h1;
            down_reg       <= 1'b0;
            attach_win_reg <= 1'b1;
         end else if (state_reg == ST_ACTIVE && state_next == ST_TRANS) begin
            prof_reg       <= profile_i;
            down_reg       <= profile_i < prof_reg;
            attach_win_reg <= 1'b0;
         end
      end
   end

   // ***********************************************
   // Pin drivers
   // ***********************************************
   logic path_on, vdd_ok, disch_next, disch_reg, path_reg;
   logic [3:0] flag_reg;

   // Each supply check counts only when selected
   assign vdd_ok = (!uvlo_sel_i || sync_reg.vdd_uv_ok) &&
                   (!ovlo_sel_i || sync_reg.vdd_ov_ok);
   // Profile steps bypass the range check since the bus is moving
   assign path_on = vdd_ok && attached_i &&
                    ((state_reg == ST_ACTIVE && sync_reg.vbus_valid) ||
                     (state_reg == ST_TRANS &&
                      (sync_reg.vbus_valid || !attach_win_reg)));
   assign disch_next = disch_en_i &&
                       (state_reg == ST_ERROR ||
                        (state_reg == ST_IDLE && sync_reg.vbus_present) ||
                        (state_reg == ST_TRANS && down_reg));

   // Registered pin levels
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         path_reg  <= 1'b0;
         disch_reg <= 1'b0;
         flag_reg  <= FLAGS_OFF;
      end else if (ce_i) begin
         path_reg  <= path_on;
         disch_reg <= disch_next;
         flag_reg  <= (contract_i && state_next != ST_ERROR)
                      ? flag_decode(profile_i, profile_cnt_i)
                      : FLAGS_OFF;
      end
   end

   // Open drain: level low only while driven
   assign source_power_path_enable_n_o = !path_reg;
   assign path_oe_o                    = path_reg;
   assign path_status_o                = !path_reg;
   assign profile_select_flag_n_o      = ~flag_reg;
   assign flag_oe_o                    = flag_reg;
   assign external_discharge_ctrl_o    = disch_reg;
   assign internal_discharge_o         = disch_reg;
   assign cc_hiz_o                     = cc_hiz_reg;
   assign i2c_addr_bit0_o              = addr_bit0_reg;
   assign connected_o = state_reg == ST_TRANS || state_reg == ST_ACTIVE;
   assign error_recovery_o             = state_reg == ST_ERROR;

   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_path_needs_link: assert property (path_oe_o |-> $past(attached_i))
      else $error("path enabled without attachment");
   a_path_vdd_gate: assert property (ce_i && uvlo_sel_i &&
      !sync_reg.vdd_uv_ok |=> !path_oe_o)
      else $error("path enabled under UVLO");
   a_status_mirror: assert property (path_status_o ==
      source_power_path_enable_n_o)
      else $error("status bit differs from pin");
   a_strap_hold: assert property (strap_done_reg ##1 strap_done_reg
      |-> $stable(i2c_addr_bit0_o))
      else $error("address bit moved");
   a_cc_release: assert property ($fell(cc_hiz_o) |-> $past(ce_i))
      else $error("CC left released state early");
   a_flag_idle: assert property (ce_i && !contract_i |=>
      flag_oe_o == 4'h0)
      else $error("flag driven without contract");
   a_flag_pick: assert property (ce_i && contract_i &&
      profile_i == 3'h3 && profile_cnt_i >= 3'h3 && state_next != ST_ERROR
      |=> flag_oe_o == 4'h2)
      else $error("wrong flag for profile three");
   a_range_drop: assert property (ce_i && state_reg == ST_ACTIVE &&
      attached_i && !sync_reg.vbus_valid
      |=> error_recovery_o ##1 !path_oe_o)
      else $error("out of range did not drop");
   a_err_disch: assert property (ce_i && disch_en_i && error_recovery_o
      |=> external_discharge_ctrl_o)
      else $error("no discharge in recovery");
   a_window_len: assert property (state_reg == ST_TRANS |->
      win_reg < TW'(TRANS_CYCLES))
      else $error("window overran");

   c_active: cover property (state_reg == ST_TRANS ##1 state_reg == ST_ACTIVE);
   c_error: cover property (state_reg == ST_ACTIVE ##1 error_recovery_o);
   c_down_step: cover property (state_reg == ST_TRANS && down_reg &&
      external_discharge_ctrl_o);
endmodule
`default_nettype wire

// file: tb/pdsrc_partner.sv
// Regulation stage and sink model facing the power path pins
`timescale 1ns/1ns
`default_nettype none
module pdsrc_partner (
   input  wire logic       clk_i,         // Bench clock
   input  wire logic       path_oe_i,     // Path pin pulled low
   input  wire logic [3:0] flag_oe_i,     // Flag pins pulled low
   input  wire logic       disch_i,       // External discharge command
   input  wire logic       fault_i,       // Bench-commanded bus fault
   output logic            path_pin_o,    // Resolved path pin level
   output logic [3:0]      flag_pin_o,    // Resolved flag pin levels
   output logic            vbus_valid_o,  // Bus inside range
   output var logic        vbus_present_o // Bus voltage present
);
   // Pull-ups give the released level of every open-drain pin
   assign path_pin_o = path_oe_i ? 1'h0 : 1'h1;
   assign flag_pin_o = ~flag_oe_i;
   // Regulation keeps the range unless a fault is ordered
   assign vbus_valid_o = ~fault_i;
   // Bus charges with the path on, decays only under discharge
   initial vbus_present_o = 1'h0;
   always @(posedge clk_i) begin
      if (path_oe_i)
         vbus_present_o <= 1'h1;
      else if (disch_i)
         vbus_present_o <= 1'h0;
   end
endmodule
`default_nettype wire

// file: tb/pdsrc_outputs_test.sv
// Self-checking bench of the source power path output block
`timescale 1ns/1ns
`default_nettype none
module pdsrc_outputs_test;
   import pdsrc_pkg::*;
   localparam int unsigned TRANS = 20;
   localparam int unsigned ERRC  = 10;
   logic clk_i, rst_i, att, con, uv_sel, ov_sel, uv_ok, ov_ok, strap;
   logic fault, valid, present, cc_hiz, path_n, path_oe, status, path;
   logic dis_x, dis_i, i2c_address_bit0_strap, conn, err, ce, den;
   logic [2:0] prof, pcnt;
   logic [3:0] flag_n, flag_oe, flags;
   pdsrc_sense_type sense;
   int num_errors, n_checks;
   assign sense = {valid, present, uv_ok, ov_ok, strap};
   pdsrc_outputs #(.TRANS_CYCLES(TRANS), .ERR_CYCLES(ERRC)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .sense_i(sense),
      .attached_i(att), .contract_i(con), .profile_i(prof),
      .profile_cnt_i(pcnt), .uvlo_sel_i(uv_sel), .ovlo_sel_i(ov_sel),
      .disch_en_i(den), .cc_hiz_o(cc_hiz),
      .source_power_path_enable_n_o(path_n), .path_oe_o(path_oe),
      .path_status_o(status), .profile_select_flag_n_o(flag_n),
      .flag_oe_o(flag_oe), .external_discharge_ctrl_o(dis_x),
      .internal_discharge_o(dis_i), .i2c_addr_bit0_o(i2c_address_bit0_strap),
      .connected_o(conn), .error_recovery_o(err));
   pdsrc_partner i_far (
      .clk_i(clk_i), .path_oe_i(path_oe), .flag_oe_i(flag_oe),
      .disch_i(dis_x), .fault_i(fault), .path_pin_o(path),
      .flag_pin_o(flags), .vbus_valid_o(valid),
      .vbus_present_o(present));
   // ***********************************************
   // Clock and helpers
   // ***********************************************
   initial begin
      clk_i = 1'h0;
      forever #2 clk_i = ~clk_i;
   end
   task automatic chk(input logic [3:0] got, exp, input string what);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Bounded wait for recovery to finish; a hang ends the run
   task automatic wait_idle;
      int i;
      for (i = 0; i < ERRC + 20 && err !== 1'h0; i++)
         cyc(1);
      if (err !== 1'h0) begin
         chk(err, 1'h0, "recovery hang");
         wrap_up();
      end
   endtask
   // ***********************************************
   // Scenarios
   // ***********************************************
   task automatic t_reset;
      cyc(3);
      chk(cc_hiz, 1'h1, "cc in reset");
      chk({path, dis_x}, 2'h2, "pins in reset");
      rst_i = 1'h0;
      cyc(4);
      chk(cc_hiz, 1'h0, "cc after reset");
      chk(i2c_address_bit0_strap, 1'h1, "strap taken");
      strap = 1'h0;
      cyc(4);
      chk(i2c_address_bit0_strap, 1'h1, "strap held");
   endtask
   task automatic t_attach;
      att = 1'h1;
      cyc(3);
      chk({path, status, conn}, 3'h1, "attach path");
      chk(flags, 4'hF, "no contract flags");
      cyc(TRANS + 4);
      chk({path, conn, err}, 3'h2, "active");
   endtask
   task automatic t_profiles;
      int p;
      logic [3:0] e;
      con = 1'h1;
      for (p = 1; p <= 5; p++) begin
         prof = 3'(p);
         cyc(2);
         e = p < 2 ? 4'hF : ~(4'h1 << (p - 2));
         chk(flags, e, "flag");
         chk(flag_n, e, "flag level");
         chk(path, 1'h0, "path in step window");
      end
      pcnt = 3'h4;
      cyc(2);
      chk(flags, 4'hF, "beyond count");
      pcnt = 3'h5;
      prof = 3'h1;
      cyc(TRANS + 4);
   endtask
   task automatic t_lockout;
      uv_ok = 1'h0;
      cyc(5);
      chk(path, 1'h0, "uv unselected");
      uv_sel = 1'h1;
      cyc(5);
      chk(path, 1'h1, "uv lockout");
      uv_ok = 1'h1;
      ov_ok = 1'h0;
      cyc(5);
      chk(path, 1'h0, "ov unselected");
      ov_sel = 1'h1;
      cyc(5);
      chk(path, 1'h1, "ov lockout");
      ov_ok = 1'h1;
      cyc(5);
      chk(path, 1'h0, "lockouts clear");
   endtask
   task automatic t_fault;
      fault = 1'h1;
      cyc(5);
      chk({err, conn, path, dis_x}, 4'hB, "bus fault");
      chk(flags, 4'hF, "flags in error");
      att = 1'h0;
      fault = 1'h0;
      wait_idle();
      fault = 1'h1;
      cyc(3);
      att = 1'h1;
      cyc(3);
      chk(path, 1'h1, "attach blocked");
      cyc(TRANS);
      chk({err, conn, dis_x}, 3'h5, "attach fault");
      att = 1'h0;
      fault = 1'h0;
      wait_idle();
   endtask
   task automatic t_detach;
      att = 1'h1;
      cyc(TRANS + 6);
      chk({path, present}, 2'h1, "powered");
      ce = 1'h0;
      prof = 3'h3;
      cyc(4);
      chk(flags, 4'hF, "frozen flags");
      chk({path, conn}, 2'h1, "frozen path");
      prof = 3'h1;
      ce = 1'h1;
      att = 1'h0;
      cyc(3);
      chk({path, dis_x}, 2'h3, "detach");
      chk({path_n, dis_i}, 2'h3, "detach pins");
      cyc(6);
      chk({present, dis_x}, 2'h0, "drained");
      att = 1'h1;
      cyc(TRANS + 6);
      den = 1'h0;
      att = 1'h0;
      cyc(4);
      chk({present, dis_x}, 2'h2, "discharge barred");
      den = 1'h1;
      cyc(9);
      chk({present, dis_i}, 2'h0, "drained late");
   endtask
   // ***********************************************
   // Main sequence
   // ***********************************************
   initial begin
      num_errors = 0;
      n_checks = 0;
      rst_i = 1'h1;
      {att, con, uv_sel, ov_sel, fault} = 5'h0;
      {ce, den} = 2'h3;
      {uv_ok, ov_ok, strap} = 3'h7;
      prof = 3'h1;
      pcnt = 3'h5;
      cyc(13);
      t_reset();
      t_attach();
      t_profiles();
      t_lockout();
      t_fault();
      t_detach();
      wrap_up();
   end
endmodule
`default_nettype wire
